// File: logic/mucp_dev.sv
// module: flash side address capture front end, link clock domain
// ************************************************************
// Summary of operation
// - async mode: indicator shows valid data when driven
// - sync mode: valid only after latency elapses
// - host strobes once or twice per async cycle
// - first strobe with enable low captures upper half
// - second strobe with enable high captures lower half
// - host always supplies a lower address strobe
// - async reads sense on lower half latch
// - no upper phase reuses last upper half
// - async access timed from strobe rising edge
// - host restarts pending read at most once
// - sync: upper with enable low, then lower
// - sync: latch on clock edge, sense after lower
// - sync: strobe held low captures both consecutively
// - mode only when config bit four set
// - entering mode presets upper half to zeros
// - indicator driven exactly when data lines driven
// ************************************************************
`timescale 1ns/1ps
`default_nettype none
module mucp_dev
    import mucp_pkg::*;
(
    mucp_if.dev bus,
    input wire logic clk,
    input wire logic rstn,
    input wire logic [MUCP_RCR_W-1:0] cfg_wdata,
    input wire logic cfg_we,
    input wire logic [MUCP_DQ_W-1:0] array_rdata,
    output logic [MUCP_RCR_W-1:0] cfg_rdata,
    output logic [MUCP_UP_W+MUCP_DQ_W-1:0] sense_addr,
    output logic sense_start,
    output logic [MUCP_UP_W-1:0] upper_addr
);
    // ************************************************************
    // configuration crossing: clk domain register, link side sync
    // ************************************************************
    logic [MUCP_RCR_W-1:0] cfg_reg; // read configuration register, clk domain
    logic [MUCP_RCR_W-1:0] cfg_s1_reg; // first sync stage, read by second only
    logic [MUCP_RCR_W-1:0] cfg_s2_reg; // link side copy
    logic lrst_s1_reg; // reset synchroniser first stage
    logic lrstn_reg; // link side reset, active low
    // config written by the local core; quasi-static, so a multibit sync is safe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg_reg <= MUCP_RCR_RST;
        end else if (cfg_we) begin
            cfg_reg <= cfg_wdata;
        end
    end
    assign cfg_rdata = cfg_reg;
    // bring config and reset into the link domain
    always_ff @(posedge bus.link_clk) begin
        cfg_s1_reg <= cfg_reg;
        cfg_s2_reg <= cfg_s1_reg;
        lrst_s1_reg <= rstn;
        lrstn_reg <= lrst_s1_reg;
    end
    wire mode_en = cfg_s2_reg[MUCP_MODE_BIT];
    wire async_mode = cfg_s2_reg[MUCP_ASYNC_BIT];
    // ************************************************************
    // strobe edge detection on the link clock
    // ************************************************************
    logic adv_d_reg; // strobe one link clock ago
    logic phase_reg; // declared but never assigned or read
    logic mode_d_reg; // mode enable one clock ago
    always_ff @(posedge bus.link_clk) begin
        if (!lrstn_reg) begin
            adv_d_reg <= 1'b1;
            mode_d_reg <= 1'b0;
        end else begin
            adv_d_reg <= bus.address_valid_n;
            mode_d_reg <= mode_en;
        end
    end
    wire adv_rise = !adv_d_reg && bus.address_valid_n;
    // async captures on the strobe rise; sync on each clock with strobe low
    wire cap_evt = async_mode ? adv_rise : !bus.address_valid_n;
    wire cap_up = mode_en && cap_evt && !bus.oe_n;
    wire cap_lo = cap_evt && bus.oe_n;
    wire mode_entry = mode_en && !mode_d_reg;
    // ************************************************************
    // upper address holding register
    // ************************************************************
    // persists across cycles; a single-phase cycle reuses it
    always_ff @(posedge bus.link_clk) begin
        if (!lrstn_reg) begin
            upper_addr <= MUCP_UP_RST;
        end else if (mode_entry) begin
            upper_addr <= MUCP_UP_RST;
        end else if (cap_up) begin
            upper_addr <= bus.dq;
        end
    end
    // ************************************************************
    // sense and output sequencer
    // ************************************************************
    mucp_dev_state_t state_reg;
    logic [7:0] cnt_reg; // access or latency countdown
    logic [MUCP_DQ_W-1:0] data_reg; // word to present
    logic valid_reg; // output word is valid
    wire [7:0] wait_cyc = async_mode ? 8'(MUCP_ACCESS_CYC) : 8'(MUCP_LATENCY_CYC);
    // a new lower capture restarts sensing; the host limits restarts
    always_ff @(posedge bus.link_clk) begin
        if (!lrstn_reg) begin
            state_reg <= MUCP_IDLE;
            cnt_reg <= 8'h00;
            valid_reg <= 1'b0;
            sense_start <= 1'b0;
            sense_addr <= '0;
            data_reg <= '0;
        end else begin
            sense_start <= 1'b0;
            if (cap_lo) begin
                // sensing starts on the lower latch
                state_reg <= MUCP_SENSE;
                cnt_reg <= wait_cyc;
                valid_reg <= 1'b0;
                sense_start <= 1'b1;
                sense_addr <= {mode_en ? upper_addr : MUCP_UP_RST, bus.dq};
            end else begin
                case (state_reg)
                    MUCP_IDLE: begin
                        valid_reg <= 1'b0;
                    end
                    MUCP_SENSE: begin
                        // count the access or latency time; data is valid after it
                        if (cnt_reg <= 8'h01) begin
                            state_reg <= MUCP_DRIVE;
                            data_reg <= array_rdata;
                            valid_reg <= 1'b1;
                        end else begin
                            cnt_reg <= cnt_reg - 8'h01;
                        end
                    end
                    MUCP_DRIVE: begin
                        data_reg <= array_rdata;
                    end
                    default: begin
                        state_reg <= MUCP_IDLE;
                    end
                endcase
            end
        end
    end
    // ************************************************************
    // pin drive
    // ************************************************************
    // async mode drives only once the word is valid, so a driven indicator always means valid
    wire word_ready = async_mode ? state_reg == MUCP_DRIVE : state_reg != MUCP_IDLE;
    wire drive = !bus.oe_n && bus.address_valid_n && word_ready;
    assign bus.dev_dq_o = data_reg;
    assign bus.dev_dq_oe = drive;
    assign bus.data_valid_oe = drive;
    assign bus.data_valid_o = valid_reg && state_reg == MUCP_DRIVE;
endmodule
`default_nettype wire

// File: logic/mucp_pkg.sv
// package: shared constants and types for the muxed upper address capture port
package mucp_pkg;
    // ************************************************************
    // widths and field positions
    // ************************************************************
    localparam int MUCP_DQ_W = 16; // multiplexed address/data lines
    localparam int MUCP_UP_W = 16; // upper address field width
    localparam int MUCP_RCR_W = 16; // read configuration register width
    localparam int MUCP_MODE_BIT = 4; // upper address mux mode enable bit
    localparam int MUCP_ASYNC_BIT = 15; // 1 = asynchronous, 0 = synchronous
    // ************************************************************
    // reset values and counts
    // ************************************************************
    localparam logic [15:0] MUCP_RCR_RST = 16'h0000; // plain mux mode after reset
    localparam logic [15:0] MUCP_UP_RST = 16'h0000; // upper half preset to zeros
    localparam int MUCP_LATENCY_CYC = 3; // sync latency in link clocks
    localparam int MUCP_ACCESS_NS = 96; // async access from strobe rise
    localparam int MUCP_LINK_NS = 12; // link clock period
    localparam int MUCP_ACCESS_CYC = (MUCP_ACCESS_NS + MUCP_LINK_NS - 1) / MUCP_LINK_NS;
    localparam int MUCP_HOST_DIV = 2; // host link clock half period in clk cycles
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {MUCP_IDLE, MUCP_SENSE, MUCP_DRIVE} mucp_dev_state_t;
    typedef enum logic [2:0] {MUCP_H_IDLE, MUCP_H_UP, MUCP_H_LO, MUCP_H_GAP,
        MUCP_H_WAIT, MUCP_H_DONE} mucp_host_state_t;
endpackage

// File: logic/mucp_if.sv
// interface: pins between host controller and flash front end
`timescale 1ns/1ps
`default_nettype none
interface mucp_if;
    import mucp_pkg::*;
    logic link_clk; // link clock, made by the host
    logic address_valid_n; // address strobe, active low
    logic oe_n; // output enable, active low, selects upper half when low
    logic [MUCP_DQ_W-1:0] host_dq_o; // host drive of the shared lines
    logic host_dq_oe; // host drives the lines
    logic [MUCP_DQ_W-1:0] dev_dq_o; // device drive of the shared lines
    logic dev_dq_oe; // device drives the lines
    logic data_valid_o; // data valid indicator level
    logic data_valid_oe; // data valid indicator driven
    logic [MUCP_DQ_W-1:0] dq; // resolved bus level
    // resolve the shared lines from the enables
    assign dq = host_dq_oe ? host_dq_o : (dev_dq_oe ? dev_dq_o : '0);
    modport dev (input link_clk, address_valid_n, oe_n, dq,
        output dev_dq_o, dev_dq_oe, data_valid_o, data_valid_oe);
    modport host (output link_clk, address_valid_n, oe_n, host_dq_o, host_dq_oe,
        input dq, data_valid_o, data_valid_oe);
endinterface
`default_nettype wire

// File: logic/mucp_host.sv
// module: host controller end, makes the link clock by division
`timescale 1ns/1ps
`default_nettype none
module mucp_host
    import mucp_pkg::*;
(
    mucp_if.host bus,
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_two_phase,
    input wire logic [MUCP_UP_W+MUCP_DQ_W-1:0] req_addr,
    output logic rsp_valid,
    output logic [MUCP_DQ_W-1:0] rsp_data
);
    // ************************************************************
    // link clock divider and edge tick
    // ************************************************************
    logic [7:0] div_reg; // divider count
    logic lclk_reg; // link clock level
    logic dv_s1_reg; // valid indicator sync stage one
    logic dv_s2_reg; // valid indicator sync stage two
    always_ff @(posedge clk) begin
        if (!rstn) begin
            div_reg <= 8'h00;
            lclk_reg <= 1'b0;
        end else if (div_reg == 8'(MUCP_HOST_DIV - 1)) begin
            div_reg <= 8'h00;
            lclk_reg <= !lclk_reg;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    // pins change just after the link clock falls, away from the rising edge
    wire tick = div_reg == 8'(MUCP_HOST_DIV - 1) && lclk_reg;
    assign bus.link_clk = lclk_reg;
    // valid indicator enters from outside; two flops before use
    always_ff @(posedge clk) begin
        dv_s1_reg <= bus.data_valid_o && bus.data_valid_oe;
        dv_s2_reg <= dv_s1_reg;
    end
    // ************************************************************
    // sync cycle sequencer: one or two address phases
    // ************************************************************
    mucp_host_state_t st_reg;
    logic [MUCP_UP_W+MUCP_DQ_W-1:0] addr_reg; // latched request address
    logic adv_n_reg; // strobe level
    logic oe_n_reg; // output enable level
    logic dq_oe_reg; // host drives lines
    logic [MUCP_DQ_W-1:0] dq_reg; // host line value
    assign req_ready = st_reg == MUCP_H_IDLE;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg <= MUCP_H_IDLE;
            addr_reg <= '0;
            adv_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
            dq_reg <= '0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end else begin
            rsp_valid <= 1'b0;
            case (st_reg)
                MUCP_H_IDLE: begin
                    if (req_valid) begin
                        addr_reg <= req_addr;
                        st_reg <= req_two_phase ? MUCP_H_UP : MUCP_H_LO;
                    end
                end
                MUCP_H_UP: begin
                    if (tick) begin
                        // upper half first with enable low
                        adv_n_reg <= 1'b0;
                        oe_n_reg <= 1'b0;
                        dq_oe_reg <= 1'b1;
                        dq_reg <= addr_reg[MUCP_UP_W+MUCP_DQ_W-1:MUCP_DQ_W];
                        st_reg <= MUCP_H_LO;
                    end
                end
                MUCP_H_LO: begin
                    if (tick) begin
                        // strobe stays low into the lower phase
                        adv_n_reg <= 1'b0;
                        oe_n_reg <= 1'b1;
                        dq_oe_reg <= 1'b1;
                        dq_reg <= addr_reg[MUCP_DQ_W-1:0];
                        st_reg <= MUCP_H_GAP;
                    end
                end
                MUCP_H_GAP: begin
                    if (tick) begin
                        // release the lines before enabling output
                        adv_n_reg <= 1'b1;
                        dq_oe_reg <= 1'b0;
                        st_reg <= MUCP_H_WAIT;
                    end
                end
                MUCP_H_WAIT: begin
                    // one read at a time, never restarted early
                    oe_n_reg <= 1'b0;
                    if (dv_s2_reg) begin
                        rsp_data <= bus.dq;
                        rsp_valid <= 1'b1;
                        st_reg <= MUCP_H_DONE;
                    end
                end
                MUCP_H_DONE: begin
                    oe_n_reg <= 1'b1;
                    if (tick) begin
                        st_reg <= MUCP_H_IDLE;
                    end
                end
                default: begin
                    st_reg <= MUCP_H_IDLE;
                end
            endcase
        end
    end
    assign bus.address_valid_n = adv_n_reg;
    assign bus.oe_n = oe_n_reg;
    assign bus.host_dq_o = dq_reg;
    assign bus.host_dq_oe = dq_oe_reg;
endmodule
`default_nettype wire

// File: bench/mucp_checker.sv
// checker: link-side properties of the joined host and device ends
`timescale 1ns/1ps
`default_nettype none
module mucp_checker (
    input wire logic link_clk,
    input wire logic rstn,
    input wire logic address_valid_n,
    input wire logic oe_n,
    input wire logic host_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic data_valid_o,
    input wire logic data_valid_oe
);
    // ************************************************************
    // clocking and helpers
    // ************************************************************
    // one domain watched, so clock and reset are given once
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!rstn);
    logic valid_seen; // indicator driven and showing valid
    logic lower_phase; // strobe low with enable high: lower half on the lines
    assign valid_seen = data_valid_o && data_valid_oe;
    assign lower_phase = !address_valid_n && oe_n;
    // ************************************************************
    // properties
    // ************************************************************
    // indicator enable follows the data line enable exactly
    property p_valid_tracks_drive;
        data_valid_oe == dev_dq_oe;
    endproperty
    a_valid_tracks_drive: assert property (p_valid_tracks_drive)
        else $error("indicator enable differs from data enable");
    // the two ends never drive the shared lines together
    property p_no_contention;
        !(host_dq_oe && dev_dq_oe);
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("both ends drive the shared lines");
    // device drives only with enable low and no address phase running
    property p_drive_only_when_enabled;
        dev_dq_oe |-> !oe_n && address_valid_n;
    endproperty
    a_drive_only_when_enabled: assert property (p_drive_only_when_enabled)
        else $error("device drives outside its output window");
    // upper phase is followed at once by the lower phase
    property p_upper_then_lower;
        (!address_valid_n && !oe_n) |=> lower_phase;
    endproperty
    a_upper_then_lower: assert property (p_upper_then_lower)
        else $error("upper phase not followed by lower phase");
    // strobe held low for one or two clocks only
    property p_strobe_width;
        $fell(address_valid_n) |=> ##[0:1] address_valid_n;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("address strobe held too long");
    // no valid indication before the latency has run
    property p_latency_quiet;
        lower_phase |=> !valid_seen [*3];
    endproperty
    a_latency_quiet: assert property (p_latency_quiet)
        else $error("valid shown before latency elapsed");
    // valid indication arrives within a bounded time
    property p_latency_bound;
        lower_phase |-> ##[4:40] valid_seen;
    endproperty
    a_latency_bound: assert property (p_latency_bound)
        else $error("valid never shown after lower capture");
    // once valid, it stays while the output window stays open
    property p_valid_holds;
        valid_seen && !oe_n |=> valid_seen || oe_n || !address_valid_n;
    endproperty
    a_valid_holds: assert property (p_valid_holds)
        else $error("valid dropped while output enabled");
endmodule
`default_nettype wire

// File: bench/mucp_bench.sv
// testbench: host and device joined, plus a bench-driven async device
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module mucp_bench;
    int n_fail = 0; // mismatches
    int n_checks = 0; // comparisons made
    logic clk = 1'b0;
    logic link2 = 1'b0; // bench link clock of the async device
    logic rstn = 1'b0;
    logic rstn_host = 1'b0; // host leaves reset first so the link clock runs during device reset
    logic [15:0] cfg_wdata = 16'h0000, cfg2_wdata = 16'h0000, array_rdata = 16'h0000;
    logic cfg_we = 1'b0, cfg2_we = 1'b0, req_valid = 1'b0, req_two_phase = 1'b0;
    logic [31:0] req_addr = 32'h00000000;
    logic req_ready, rsp_valid, sense_start, sense_start2;
    logic [15:0] rsp_data, cfg_rdata, cfg2_rdata, upper_addr, upper_addr2;
    logic [31:0] sense_addr, sense_addr2, got1, got2, ph_dq;
    logic [1:0] ph_oe; // enable level seen in the last two address phases
    mucp_if bus1();
    mucp_if bus2();
    assign bus2.link_clk = link2;
    // ************************************************************
    // ends under test and checker
    // ************************************************************
    mucp_host mucp_host_i (.bus(bus1), .clk(clk), .rstn(rstn_host), .req_valid(req_valid),
        .req_ready(req_ready), .req_two_phase(req_two_phase), .req_addr(req_addr),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    mucp_dev mucp_dev_i (.bus(bus1), .clk(clk), .rstn(rstn), .cfg_wdata(cfg_wdata),
        .cfg_we(cfg_we), .array_rdata(array_rdata), .cfg_rdata(cfg_rdata),
        .sense_addr(sense_addr), .sense_start(sense_start), .upper_addr(upper_addr));
    // second device faces the bench, which plays an async host
    mucp_dev mucp_dev_i2 (.bus(bus2), .clk(clk), .rstn(rstn), .cfg_wdata(cfg2_wdata),
        .cfg_we(cfg2_we), .array_rdata(array_rdata), .cfg_rdata(cfg2_rdata),
        .sense_addr(sense_addr2), .sense_start(sense_start2), .upper_addr(upper_addr2));
    mucp_checker mucp_checker_i (.link_clk(bus1.link_clk), .rstn(rstn),
        .address_valid_n(bus1.address_valid_n), .oe_n(bus1.oe_n),
        .host_dq_oe(bus1.host_dq_oe), .dev_dq_oe(bus1.dev_dq_oe),
        .data_valid_o(bus1.data_valid_o), .data_valid_oe(bus1.data_valid_oe));
    // ************************************************************
    // clocks and monitors
    // ************************************************************
    initial forever #5 clk = ~clk;
    // odd start offset keeps the link clock out of phase with clk
    initial begin
        #3;
        forever #6 link2 = ~link2;
    end
    // keep the sensed address of each device
    always @(posedge bus1.link_clk) if (sense_start === 1'b1) got1 <= sense_addr;
    always @(posedge link2) if (sense_start2 === 1'b1) got2 <= sense_addr2;
    // record what the wire carried in each address phase
    always @(posedge bus1.link_clk) begin
        if (bus1.address_valid_n === 1'b0) begin
            ph_dq <= {ph_dq[15:0], bus1.dq};
            ph_oe <= {ph_oe[0], bus1.oe_n};
        end
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a wait that ran out ends the run
    task automatic timeout_hit();
        `CHK(1'b0, 1'b1)
        print_verdict();
    endtask
    // config write, then time for the link side to see it
    task automatic cfg_write(input logic which, input logic [15:0] d);
        @(negedge clk);
        cfg_wdata = d;
        cfg2_wdata = d;
        cfg_we = !which;
        cfg2_we = which;
        @(negedge clk);
        cfg_we = 1'b0;
        cfg2_we = 1'b0;
        `CHK(which ? cfg2_rdata : cfg_rdata, d)
        repeat (20) @(negedge clk);
    endtask
    // one host request; judges data, sensed address, held upper half and wire phases
    task automatic host_read(input logic [31:0] a, input logic two, input logic [31:0] exp);
        int i;
        @(negedge clk);
        array_rdata = a[15:0] ^ 16'h5a5a;
        got1 = 32'h00000000;
        req_addr = a;
        req_two_phase = two;
        req_valid = 1'b1;
        for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clk);
        if (i == 50) timeout_hit();
        @(negedge clk);
        req_valid = 1'b0;
        for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) @(negedge clk);
        if (i == 400) timeout_hit();
        `CHK(rsp_data, a[15:0] ^ 16'h5a5a)
        `CHK(got1, exp)
        `CHK(upper_addr, exp[31:16])
        `CHK({ph_oe[0], ph_dq[15:0]}, {1'b1, a[15:0]})
        if (two) `CHK({ph_oe[1], ph_dq[31:16]}, {1'b0, a[31:16]})
    endtask
    // one async address strobe on the second device, hold times kept
    task automatic strobe2(input logic oe, input logic [15:0] d);
        @(negedge clk);
        bus2.oe_n = oe;
        bus2.host_dq_o = d;
        bus2.host_dq_oe = 1'b1;
        repeat (3) @(negedge clk);
        bus2.address_valid_n = 1'b0;
        repeat (4) @(negedge clk);
        bus2.address_valid_n = 1'b1;
        repeat (3) @(negedge clk);
        bus2.host_dq_oe = 1'b0;
    endtask
    // async two-strobe read, then a one-strobe cycle reusing the upper half
    task automatic async_read();
        int i;
        cfg_write(1'b1, 16'h8010);
        array_rdata = 16'h3c96;
        strobe2(1'b0, 16'h7e01);
        strobe2(1'b1, 16'h0420);
        repeat (4) @(negedge clk);
        `CHK(got2, 32'h7e010420)
        `CHK(upper_addr2, 16'h7e01)
        bus2.oe_n = 1'b0;
        @(negedge clk);
        `CHK(bus2.data_valid_o & bus2.data_valid_oe, 1'b0)
        for (i = 0; i < 60 && bus2.data_valid_oe !== 1'b1; i++) @(negedge clk);
        if (i == 60) timeout_hit();
        `CHK(bus2.data_valid_o, 1'b1)
        `CHK(bus2.dq, 16'h3c96)
        bus2.oe_n = 1'b1;
        @(negedge clk);
        `CHK(bus2.data_valid_oe, 1'b0)
        strobe2(1'b1, 16'h0555);
        repeat (4) @(negedge clk);
        `CHK(got2, 32'h7e010555)
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        bus2.address_valid_n = 1'b1;
        bus2.oe_n = 1'b1;
        bus2.host_dq_o = 16'h0000;
        bus2.host_dq_oe = 1'b0;
        repeat (4) @(negedge clk);
        rstn_host = 1'b1;
        // long enough for four edges of the slower link clock as well
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        `CHK(cfg_rdata, 16'h0000)
        `CHK(upper_addr, 16'h0000)
        `CHK(bus1.data_valid_oe, 1'b0)
        host_read(32'h12340001, 1'b1, 32'h00000001);
        cfg_write(1'b0, 16'h0010);
        `CHK(upper_addr, 16'h0000)
        host_read(32'habcd5678, 1'b1, 32'habcd5678);
        host_read(32'hffff9abc, 1'b0, 32'habcd9abc);
        cfg_write(1'b0, 16'h0000);
        cfg_write(1'b0, 16'h0010);
        `CHK(upper_addr, 16'h0000)
        async_read();
        print_verdict();
    end
endmodule
`default_nettype wire
